// [design/thcp_parser.sv]
// Host command interpreter of the matrix touch-key controller
`timescale 1ns/1ps
`include "thcp_consts.svh"
module thcp_parser #(
  parameter int unsigned TMO_CYC = `THCP_TMO_MS * 1000 * `THCP_CLK_MHZ,
  parameter logic [7:0] CRC8_POLY = `THCP_CRC8_POLY,
  parameter logic [7:0] CRC8_INIT = `THCP_CRC8_INIT,
  parameter logic [15:0] CRC16_POLY = `THCP_CRC16_POLY,
  parameter logic [15:0] CRC16_INIT = `THCP_CRC16_INIT
) (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Host byte link
  input logic spi_mode,
  input logic rx_valid,
  input logic [7:0] rx_data,
  output logic tx_valid,
  input logic tx_ready,
  output logic [7:0] tx_data,
  // Sensing data
  input logic [47:0] key_det,
  output logic [5:0] key_idx,
  output logic key_ref_sel,
  input logic [15:0] key_word,
  // Status sources
  input logic fmea_fault,
  input logic calibrating,
  input logic cal_fail,
  input logic sync_fail,
  input logic eeprom_corrupt,
  input logic comms_err_set,
  output logic comms_err,
  // Sensing control
  output logic sense_halt,
  output logic cal_all_req,
  output logic reset_req,
  // Configuration storage
  output logic cfg_we,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_data,
  output logic cfg_commit,
  output logic cfg_mark_valid
);
  import thcp_pkg::*;

  localparam logic [24:0] TMO_M1 = 25'(TMO_CYC - 1);

  thcp_regs_t q, d;
  logic f_in_ready, f_out_valid, f_out_ready, f_push, slot, gate;
  logic [7:0] f_out_data;
  logic [7:0] sel, ndat;
  logic has_crc, multi, any_err, good, is_null, pop;
  logic [5:0] fk;
  logic [47:0] kshift;

  // CRC-8 step, MSB first
  function automatic logic [7:0] crc8_f(input logic [7:0] c,
                                        input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC8_POLY) : (r << 1);
    end
    return r;
  endfunction : crc8_f

  // CRC-16 step, MSB first
  function automatic logic [15:0] crc16_f(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC16_POLY) : (r << 1);
    end
    return r;
  endfunction : crc16_f

  thcp_fifo #(
    .W(`THCP_FIFO_W),
    .D(`THCP_FIFO_D)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(q.pv),
    .in_ready(f_in_ready),
    .in_data(q.pdata),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // In SPI mode a byte leaves only against a banked null command
  assign gate = !spi_mode || (q.credit != 6'h00);
  assign tx_valid = f_out_valid && gate;
  assign f_out_ready = tx_ready && gate;
  assign tx_data = f_out_data;
  assign pop = f_out_valid && f_out_ready;
  assign f_push = q.pv && f_in_ready;
  assign slot = !q.pv || f_in_ready;

  assign key_idx = q.cnt[6:1];
  assign key_ref_sel = (q.cmd == `THCP_CMD_REF);
  assign comms_err = q.comms_err;
  assign sense_halt = q.halt;
  assign cal_all_req = q.cal_req;
  assign reset_req = q.rst_req;
  assign cfg_we = q.cfg_we;
  assign cfg_addr = q.cfg_addr;
  assign cfg_data = q.cfg_data;
  assign cfg_commit = q.cfg_commit;
  assign cfg_mark_valid = q.cfg_valid;

  assign is_null = rx_valid && spi_mode && (q.st != ST_UPLD) &&
                   (rx_data == `THCP_CMD_NULL);
  assign multi = |(key_det & (key_det - 48'h1));
  assign any_err = calibrating | cal_fail | sync_fail | q.comms_err |
                   fmea_fault | eeprom_corrupt;
  assign kshift = key_det >> (6'd40 - {q.cnt[2:0], 3'b000});
  assign good = (q.rxcrc == `THCP_CRC_SKIP) || (q.rxcrc == q.crc16);

  // Lowest touched key, or the none code
  always_comb begin
    fk = `THCP_NOKEY;
    for (int k = 47; k >= 0; k--) begin
      if (key_det[k]) begin
        fk = 6'(k);
      end
    end
  end

  // Report byte for the current position
  always_comb begin
    sel = 8'h00;
    ndat = `THCP_ONE_BYTES;
    has_crc = 1'b1;
    case (q.cmd)
      `THCP_CMD_ERR: begin
        sel[`THCP_ST_FMEA_BIT] = fmea_fault;
        sel[`THCP_ST_COMMS_BIT] = q.comms_err;
      end
      `THCP_CMD_FIRST: begin
        sel = {multi, any_err, fk};
      end
      `THCP_CMD_ALL: begin
        sel = kshift[7:0];
        ndat = `THCP_KMAP_BYTES;
      end
      `THCP_CMD_SIG, `THCP_CMD_REF: begin
        sel = q.cnt[0] ? key_word[7:0] : key_word[15:8];
        ndat = `THCP_DUMP_BYTES;
        has_crc = 1'b0;
      end
      default: begin
        sel = 8'h00;
      end
    endcase
  end

  always_comb begin
    d = q;
    d.cal_req = 1'b0;
    d.rst_req = 1'b0;
    d.cfg_we = 1'b0;
    d.cfg_commit = 1'b0;
    d.cfg_valid = 1'b0;
    if (f_in_ready) begin
      d.pv = 1'b0;
    end
    if (is_null && !pop && q.credit != 6'h3f) begin
      d.credit = q.credit + 6'h01;
    end else if (pop && !is_null && spi_mode) begin
      d.credit = q.credit - 6'h01;
    end
    if (q.arm_v) begin
      d.tmr = q.tmr + 25'h1;
      if (q.tmr == TMO_M1) begin
        d.arm_v = 1'b0;
      end
    end
    case (q.st)
      ST_IDLE: begin
        if (rx_valid) begin
          if (rx_data == `THCP_CMD_LAST) begin
            d.comms_err = 1'b0;
          end
          if (q.arm_v && rx_data == q.arm_code) begin
            d.arm_v = 1'b0;
            d.cmd = rx_data;
            if (rx_data == `THCP_CMD_CFG) begin
              d.halt = 1'b1;
              d.st = ST_UPRDY;
            end else begin
              d.st = ST_ACK;
            end
          end else if (rx_data == `THCP_CMD_CFG ||
                       rx_data == `THCP_CMD_CAL ||
                       rx_data == `THCP_CMD_RST) begin
            d.arm_v = 1'b1;
            d.arm_code = rx_data;
            d.tmr = 25'h0;
          end else begin
            d.arm_v = 1'b0;
            if (rx_data >= `THCP_CMD_ERR && rx_data <= `THCP_CMD_REF) begin
              d.cmd = rx_data;
              d.cnt = 8'h00;
              d.crc8 = crc8_f(CRC8_INIT, rx_data);
              d.st = ST_GEN;
            end
          end
        end
      end
      ST_GEN: begin
        if (slot) begin
          d.pv = 1'b1;
          d.cnt = q.cnt + 8'h01;
          if (q.cnt < ndat) begin
            d.pdata = sel;
            d.crc8 = crc8_f(q.crc8, sel);
            if (!has_crc && q.cnt == ndat - 8'h01) begin
              d.st = ST_IDLE;
            end
          end else begin
            d.pdata = q.crc8;
            d.st = ST_IDLE;
          end
        end
      end
      ST_UPRDY: begin
        if (slot) begin
          d.pv = 1'b1;
          d.pdata = `THCP_RSP_RDY;
          d.cnt = 8'h00;
          d.tmr = 25'h0;
          d.crc16 = CRC16_INIT;
          d.st = ST_UPLD;
        end
      end
      ST_UPLD: begin
        if (rx_valid) begin
          d.tmr = 25'h0;
          d.cnt = q.cnt + 8'h01;
          if (q.cnt < `THCP_CFG_LEN) begin
            d.cfg_we = 1'b1;
            d.cfg_addr = q.cnt;
            d.cfg_data = rx_data;
            d.crc16 = crc16_f(q.crc16, rx_data);
          end else if (q.cnt == `THCP_CFG_LEN) begin
            d.rxcrc[7:0] = rx_data;
          end else begin
            d.rxcrc[15:8] = rx_data;
            d.st = ST_UPEND;
          end
        end else begin
          d.tmr = q.tmr + 25'h1;
          if (q.tmr == TMO_M1) begin
            d.halt = 1'b0;
            d.st = ST_IDLE;
          end
        end
      end
      ST_UPEND: begin
        if (slot) begin
          d.pv = 1'b1;
          d.pdata = good ? `THCP_RSP_RDY : `THCP_RSP_BAD;
          d.cfg_commit = 1'b1;
          d.cfg_valid = good;
          d.halt = 1'b0;
          d.st = ST_IDLE;
        end
      end
      ST_ACK: begin
        if (slot) begin
          d.pv = 1'b1;
          d.pdata = ~q.cmd;
          if (q.cmd == `THCP_CMD_CAL) begin
            d.cal_req = 1'b1;
            d.st = ST_IDLE;
          end else begin
            d.st = ST_RSTW;
          end
        end
      end
      ST_RSTW: begin
        // The acknowledge must have left before the reset fires
        if (!q.pv && !f_out_valid) begin
          d.rst_req = 1'b1;
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    if (comms_err_set) begin
      d.comms_err = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_arm_cal;
    q.st == ST_IDLE && rx_valid && rx_data == `THCP_CMD_CAL &&
    q.arm_v && q.arm_code == `THCP_CMD_CAL;
  endsequence
  // The request pulse is registered on the same edge as the acknowledge
  sequence s_cal_ack;
    q.pv && q.pdata == 8'hfc && cal_all_req;
  endsequence

  a_tx_credit: assert property (
    spi_mode && tx_valid |-> q.credit != 6'h00)
    else $error("byte sent without null command");
  a_cal_ack: assert property (
    s_arm_cal |-> ##[2:40] s_cal_ack)
    else $error("recalibrate not acknowledged");
  a_arm_drop: assert property (
    q.st == ST_IDLE && q.arm_v && q.tmr == TMO_M1 && !rx_valid
    |=> !q.arm_v && q.st == ST_IDLE)
    else $error("arming not dropped on timeout");
  a_upl_halt: assert property (
    q.st == ST_UPRDY |-> sense_halt ##[1:40] (f_push && q.pdata == 8'hfe))
    else $error("upload ready not sent while halted");
  a_upl_tmo: assert property (
    q.st == ST_UPLD && !rx_valid && q.tmr == TMO_M1
    |=> q.st == ST_IDLE && !sense_halt)
    else $error("upload timeout not taken");
  a_upl_end: assert property (
    q.st == ST_UPEND && slot && !good
    |=> q.pdata == 8'h00 && cfg_commit && !cfg_mark_valid && !sense_halt)
    else $error("bad CRC end wrong");
  a_err_clear: assert property (
    q.st == ST_IDLE && rx_valid && rx_data == `THCP_CMD_LAST &&
    !comms_err_set |=> !comms_err)
    else $error("comms error not cleared");
  a_multi_key: assert property (
    q.st == ST_GEN && q.cmd == `THCP_CMD_FIRST && q.cnt == 8'h00 &&
    slot && multi |=> q.pdata[7])
    else $error("multi-touch bit missing");
  a_dump_end: assert property (
    q.st == ST_GEN && q.cmd == `THCP_CMD_SIG && slot &&
    q.cnt == 8'h5f |=> q.st == ST_IDLE)
    else $error("signal dump length wrong");
  a_rst_order: assert property (
    reset_req |-> !f_out_valid && $past(q.st) == ST_RSTW)
    else $error("reset before acknowledge left");
endmodule : thcp_parser

// [design/thcp_consts.svh]
// Constants of the touch host command parser
`ifndef THCP_CONSTS_SVH
`define THCP_CONSTS_SVH
`define THCP_CMD_NULL 8'h00
`define THCP_CMD_CFG 8'h01
`define THCP_CMD_CAL 8'h03
`define THCP_CMD_RST 8'h04
`define THCP_CMD_ERR 8'h05
`define THCP_CMD_FIRST 8'h06
`define THCP_CMD_ALL 8'h07
`define THCP_CMD_SIG 8'h08
`define THCP_CMD_REF 8'h09
`define THCP_CMD_LAST 8'h0f
`define THCP_RSP_RDY 8'hfe
`define THCP_RSP_BAD 8'h00
`define THCP_CRC_SKIP 16'h0000
`define THCP_NOKEY 6'h3f
`define THCP_ONE_BYTES 8'h01
`define THCP_KMAP_BYTES 8'h06
`define THCP_DUMP_BYTES 8'h60
`define THCP_ST_FMEA_BIT 5
`define THCP_ST_COMMS_BIT 6
`define THCP_CFG_LEN 8'h80
`define THCP_TMO_MS 100
`define THCP_CLK_MHZ 200
`define THCP_FIFO_W 8
`define THCP_FIFO_D 32
`define THCP_CRC8_POLY 8'h07
`define THCP_CRC8_INIT 8'h00
`define THCP_CRC16_POLY 16'h1021
`define THCP_CRC16_INIT 16'hffff
`endif

// [design/thcp_pkg.sv]
// Types of the touch host command parser
package thcp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GEN = 3'b001,
    ST_UPRDY = 3'b010,
    ST_UPLD = 3'b011,
    ST_UPEND = 3'b100,
    ST_ACK = 3'b101,
    ST_RSTW = 3'b110
  } thcp_state_t;

  typedef struct packed {
    thcp_state_t st;
    logic arm_v;
    logic [7:0] arm_code;
    logic [24:0] tmr;
    logic [7:0] cmd;
    logic [7:0] cnt;
    logic [7:0] crc8;
    logic [15:0] crc16;
    logic [15:0] rxcrc;
    logic comms_err;
    logic [5:0] credit;
    logic halt;
    logic cal_req;
    logic rst_req;
    logic cfg_we;
    logic [7:0] cfg_addr;
    logic [7:0] cfg_data;
    logic cfg_commit;
    logic cfg_valid;
    logic pv;
    logic [7:0] pdata;
  } thcp_regs_t;
endpackage : thcp_pkg

// [design/thcp_fifo.sv]
// Response byte FIFO held in flip-flops
`timescale 1ns/1ps
module thcp_fifo #(
  parameter int W = 8,
  parameter int D = 32,
  parameter int AW = $clog2(D)
) (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Fill side
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } thcp_fifo_st_t;

  thcp_fifo_st_t q, d;
  logic full, empty;

  assign empty = (q.wp == q.rp);
  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = q.mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid && !full) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : thcp_fifo

// [verification/thcp_host_model.sv]
// Host-side model: sends command bytes and takes response bytes
`timescale 1ns/1ps
module thcp_host_model (
  // Clock
  input logic clk,
  // Host byte link
  output logic rx_valid,
  output logic [7:0] rx_data,
  input logic tx_valid,
  output logic tx_ready,
  input logic [7:0] tx_data,
  // Pacing of the take side
  input logic stall
);
  logic [7:0] rxq[$];

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  // One byte taken per edge where valid and ready meet
  always @(posedge clk) begin
    if (tx_valid && tx_ready) rxq.push_back(tx_data);
    tx_ready <= !stall;
  end

  // One byte per call; idle data is scrambled so stale values never match
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : send
endmodule : thcp_host_model

// [verification/touch_host_command_parser_bench.sv]
// Self-checking bench of the touch host command parser
`timescale 1ns/1ps
`include "thcp_consts.svh"
module touch_host_command_parser_bench;
  logic clk, rstn, spi_mode, stall, comms_err_set;
  logic [4:0] errs;
  logic [47:0] key_det;
  logic rx_valid, tx_valid, tx_ready, key_ref_sel, comms_err, sense_halt;
  logic cal_all_req, reset_req, cfg_we, cfg_commit, cfg_mark_valid;
  logic [7:0] rx_data, tx_data, cfg_addr, cfg_data;
  logic [5:0] key_idx;
  logic [15:0] key_word;
  logic [31:0] seed = 32'h000114a9;
  logic [7:0] exq[$];
  logic [7:0] blk[$];
  int err_count = 0;
  int cmp_count = 0;
  int we_n, com_n, mk_n, cal_n, rsr_n;

  always #2.5 clk = ~clk;
  assign key_word = {key_ref_sel ? 8'ha5 : 8'h3c, 2'b00, key_idx};

  thcp_host_model host_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .stall(stall));

  thcp_parser #(.TMO_CYC(200)) dut_u (.clk(clk), .rstn(rstn),
    .spi_mode(spi_mode), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .key_det(key_det), .key_idx(key_idx), .key_ref_sel(key_ref_sel),
    .key_word(key_word), .fmea_fault(errs[4]), .calibrating(errs[0]),
    .cal_fail(errs[1]), .sync_fail(errs[2]), .eeprom_corrupt(errs[3]),
    .comms_err_set(comms_err_set), .comms_err(comms_err),
    .sense_halt(sense_halt), .cal_all_req(cal_all_req),
    .reset_req(reset_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .cfg_commit(cfg_commit),
    .cfg_mark_valid(cfg_mark_valid));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction : crc8

  function automatic logic [15:0] crc16(input logic [15:0] c,
                                        input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) r = {r[14:0], 1'b0} ^ (r[15] ? 16'h1021 : 16'h0);
    return r;
  endfunction : crc16

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Compare collected bytes against the expected queue, then clear both
  task automatic rsp(input string n);
    int i;
    i = 0;
    while (host_u.rxq.size() < exq.size() && i < 3000) begin
      @(posedge clk);
      i++;
    end
    repeat (20) @(posedge clk);
    chk(n, 16'(exq.size()), 16'(host_u.rxq.size()));
    foreach (exq[k]) if (k < host_u.rxq.size()) chk(n, exq[k], host_u.rxq[k]);
    exq.delete();
    host_u.rxq.delete();
  endtask : rsp

  // Expected data is preloaded in exq; in SPI nulls fetch the bytes
  task automatic report(input logic [7:0] c, input bit crc);
    logic [7:0] r;
    r = crc8(`THCP_CRC8_INIT, c);
    foreach (exq[k]) r = crc8(r, exq[k]);
    if (crc) exq.push_back(r);
    host_u.send(c);
    if (spi_mode) begin
      repeat (20) @(posedge clk);
      chk("spi held", 16'h0, 16'(host_u.rxq.size()));
      repeat (exq.size()) host_u.send(`THCP_CMD_NULL);
    end
    rsp("report");
  endtask : report

  // Mode 0 good CRC, 1 corrupted CRC, 2 zero CRC
  task automatic upload(input int mode);
    logic [15:0] r;
    logic [7:0] b;
    r = `THCP_CRC16_INIT;
    we_n = 0;
    com_n = 0;
    mk_n = 0;
    host_u.send(8'h01);
    host_u.send(8'h01);
    exq = {8'hfe};
    rsp("ready");
    chk("halt", 16'h1, 16'(sense_halt));
    for (int k = 0; k < 128; k++) begin
      b = 8'(rnd());
      r = crc16(r, b);
      blk.push_back(b);
      host_u.send(b);
    end
    if (mode == 1) r = ~r;
    if (mode == 2) r = 16'h0000;
    host_u.send(r[7:0]);
    host_u.send(r[15:8]);
    exq = {mode == 1 ? 8'h00 : 8'hfe};
    rsp("final");
    chk("cfg_we", 16'd128, 16'(we_n));
    chk("commit", 16'h1, 16'(com_n));
    chk("mark", 16'(mode != 1), 16'(mk_n));
    chk("halt", 16'h0, 16'(sense_halt));
  endtask : upload

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) stall <= (rnd() % 4) == 0;

  always @(posedge clk) begin
    if (cfg_we) begin
      chk("cfg_addr", 16'(we_n), {8'h00, cfg_addr});
      chk("cfg_data", {8'h00, blk.pop_front()}, {8'h00, cfg_data});
      we_n++;
    end
    com_n += int'(cfg_commit);
    mk_n += int'(cfg_mark_valid);
    cal_n += int'(cal_all_req);
    rsr_n += int'(reset_req);
  end

  // Whole run needs a few thousand cycles; this bound leaves ample room
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    logic [47:0] kd;
    logic [7:0] f;
    logic [7:0] arm[3] = '{8'h01, 8'h03, 8'h04};
    clk = 1'b0;
    rstn = 1'b0;
    spi_mode = 1'b0;
    stall = 1'b0;
    comms_err_set = 1'b0;
    errs = 5'h00;
    key_det = 48'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    errs <= 5'h10;
    comms_err_set <= 1'b1;
    @(posedge clk);
    comms_err_set <= 1'b0;
    exq = {8'h60};
    report(8'h05, 1);
    host_u.send(8'h0f);
    repeat (4) @(posedge clk);
    chk("comms_err", 16'h0, 16'(comms_err));
    exq = {8'h20};
    report(8'h05, 1);
    for (int t = 0; t < 8; t++) begin
      kd = {16'(rnd()), rnd()} & {16'(rnd()), rnd()};
      if (t < 3) kd = t == 0 ? 48'h0 : (t == 1 ? 48'h800000000000 : 48'h1);
      key_det <= kd;
      errs <= t[0] ? 5'(rnd()) : 5'h00;
      @(posedge clk);
      f = 8'h3f;
      for (int k = 47; k >= 0; k--) if (kd[k]) f = 8'(k);
      f[7] = $countones(kd) > 1;
      f[6] = |errs;
      exq = {f};
      report(8'h06, 1);
      exq = {kd[47:40], kd[39:32], kd[31:24], kd[23:16], kd[15:8], kd[7:0]};
      report(8'h07, 1);
    end
    for (int c = 8; c < 10; c++) begin
      for (int k = 0; k < 48; k++) begin
        exq.push_back(c == 9 ? 8'ha5 : 8'h3c);
        exq.push_back(8'(k));
      end
      report(8'(c), 0);
    end
    foreach (arm[j]) begin
      host_u.send(arm[j]);
      host_u.send(8'h00);
      host_u.send(arm[j]);
      repeat (300) @(posedge clk);
      rsp("lone");
    end
    cal_n = 0;
    rsr_n = 0;
    host_u.send(8'h03);
    host_u.send(8'h03);
    exq = {8'hfc};
    rsp("cal");
    chk("cal_req", 16'h1, 16'(cal_n));
    host_u.send(8'h04);
    host_u.send(8'h04);
    exq = {8'hfb};
    rsp("reset");
    chk("reset_req", 16'h1, 16'(rsr_n));
    host_u.send(8'h01);
    host_u.send(8'h01);
    exq = {8'hfe};
    rsp("ready");
    com_n = 0;
    we_n = 0;
    // Bytes taken before the cut are still written to storage
    repeat (3) blk.push_back(8'h5a);
    repeat (3) host_u.send(8'h5a);
    repeat (300) @(posedge clk);
    rsp("abandon");
    chk("abandon we", 16'h3, 16'(we_n));
    chk("abandon halt", 16'h0, 16'(sense_halt));
    chk("abandon commit", 16'h0, 16'(com_n));
    for (int m = 0; m < 3; m++) upload(m);
    spi_mode <= 1'b1;
    errs <= 5'h00;
    @(posedge clk);
    exq = {8'h00};
    report(8'h05, 1);
    finish_test();
  end
endmodule : touch_host_command_parser_bench
